// ### hdl/pfa_consts.svh
`ifndef PFA_CONSTS_SVH
`define PFA_CONSTS_SVH

// Bus register offsets (byte address, low bits)
`define PFA_OFF_W 8
`define PFA_OFF_CTRL 8'h00
`define PFA_OFF_STS 8'h04
`define PFA_OFF_MASK 8'h08
`define PFA_OFF_FPSW 8'h0C
`define PFA_OFF_FTW 8'h10

// Control flag positions
`define PFA_CTRL_EMUL 0
`define PFA_CTRL_MONITOR 1
`define PFA_CTRL_TASKSW 2
`define PFA_CTRL_RST 3'h2

// Event bit positions
`define PFA_EV_BADOP 0
`define PFA_EV_UNAVAIL 1
`define PFA_EV_RST 2'h0

// Floating-point status word stack-top field
`define PFA_TOP_LO 11
`define PFA_TOP_HI 13
`define PFA_TOP_ZERO 3'h0
`define PFA_FPSW_RST 16'h0000

// Tag word values
`define PFA_TAGS_VALID 16'h0000
`define PFA_TAGS_EMPTY 16'hFFFF

// Upper exponent bits
`define PFA_EXP_LO 64
`define PFA_EXP_HI 79
`define PFA_EXP_ONES 16'hFFFF
`define PFA_REG_RST 80'h0

`endif

// ### hdl/pfa_pkg.sv
package pfa_pkg;

  typedef struct packed {
    logic valid;
    logic clear;
    logic wr;
    logic [2:0] dst;
    logic [2:0] src;
    logic [63:0] data;
  } pk_instr_t;

  typedef struct packed {
    logic we;
    logic [2:0] idx;
    logic [79:0] data;
  } fp_wr_t;

  typedef enum logic [1:0] {
    ACT_NONE = 2'b00,
    ACT_EXEC = 2'b01,
    ACT_UNAVAIL = 2'b10,
    ACT_BADOP = 2'b11
  } gate_act_t;

  typedef struct packed {
    logic [79:0] r;
  } slot_state_t;

  typedef struct packed {
    logic [2:0] ctrl;
    logic [1:0] sts;
    logic [1:0] mask;
    logic [15:0] fpsw;
    logic [15:0] ftw;
    logic a_wr;
    logic a_rd;
    logic [7:0] a_off;
    logic [31:0] rdata;
    logic done;
    logic badop;
    logic unavail;
    logic [63:0] pk_rd;
    logic [79:0] fp_rd;
    logic irq;
  } main_state_t;

endpackage : pfa_pkg

// ### hdl/pfa_slot.sv
`timescale 1ns/1ps
`include "pfa_consts.svh"

module pfa_slot (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Packed-integer write
  input wire logic pk_we,
  input wire logic [63:0] pk_data,
  // Floating-point write
  input wire logic fp_we,
  input wire logic [79:0] fp_data,
  // Stored value
  output logic [79:0] value
);

  pfa_pkg::slot_state_t s_q;
  pfa_pkg::slot_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (pk_we) begin
      s_d.r = {`PFA_EXP_ONES, pk_data};
    end else if (fp_we) begin
      s_d.r = fp_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '{r: `PFA_REG_RST};
    end else begin
      s_q <= s_d;
    end
  end

  assign value = s_q.r;

endmodule : pfa_slot

// ### hdl/pfa_regfile.sv
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "pfa_consts.svh"

// How it works
// - Emulation flag set: packed instruction raises invalid-opcode fault, never emulated.
// - Emulation clear: execute if task-switched clear, else device-unavailable fault.
// - Eight 64-bit packed registers, indices zero to seven, form all packed state.
// - Packed register n is low 64 bits of physical register n, ignoring stack top.
// - Stack-top pointer is status word bits 11 to 13.
// - Packed writes show in low 64 bits; floating writes show in packed view.
// - Packed write forces bits 64 to 79 of that register to ones.
// - Every executed packed instruction but state clear marks all tags valid (00).
// - State clear marks all tags empty (11) and keeps register data.
// - Every executed packed instruction, state clear included, zeroes the stack-top pointer.
// - Other status word bits and other floating registers stay unchanged.
// - No floating-point exceptions raised; no status change beyond stack top.
module pfa_regfile (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Packed instruction issue
  input wire pfa_pkg::pk_instr_t instr,
  output logic instr_done,
  output logic invalid_opcode_fault,
  output logic device_unavailable_fault,
  output logic [63:0] pk_rd_data,
  // Floating-point side
  input wire pfa_pkg::fp_wr_t fp_wr,
  input wire logic [2:0] fp_rd_idx,
  output logic [79:0] fp_rd_data,
  input wire logic fpsw_we,
  input wire logic [15:0] fpsw_wdata,
  input wire logic ftw_we,
  input wire logic [15:0] ftw_wdata,
  output logic [15:0] fp_status_word,
  output logic [15:0] fp_tag_word,
  // Interrupt
  output logic irq
);

  pfa_pkg::main_state_t s_q;
  pfa_pkg::main_state_t s_d;
  pfa_pkg::gate_act_t act;
  logic [79:0] regs [8];
  logic [7:0] pk_we;
  logic [7:0] fp_we;
  logic exec;
  logic emulation_flag;
  logic task_switched_flag;
  logic ahb_go;
  logic [1:0] ev;
  logic [31:0] rd_mux;

  assign emulation_flag = s_q.ctrl[`PFA_CTRL_EMUL];
  assign task_switched_flag = s_q.ctrl[`PFA_CTRL_TASKSW];

  // Control flag gate
  always_comb begin
    if (!instr.valid) begin
      act = pfa_pkg::ACT_NONE;
    end else if (emulation_flag) begin
      act = pfa_pkg::ACT_BADOP;
    end else if (task_switched_flag) begin
      act = pfa_pkg::ACT_UNAVAIL;
    end else begin
      act = pfa_pkg::ACT_EXEC;
    end
  end

  assign exec = (act == pfa_pkg::ACT_EXEC);

  // Physical-index write enables
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pk_we[i] = exec && instr.wr && !instr.clear && (instr.dst == 3'(i));
      fp_we[i] = fp_wr.we && (fp_wr.idx == 3'(i));
    end
  end

  // Eight aliased registers
  generate
    for (genvar g = 0; g < 8; g++) begin : g_slot
      pfa_slot u_slot (
        .hclk(hclk),
        .hresetn(hresetn),
        .pk_we(pk_we[g]),
        .pk_data(instr.data),
        .fp_we(fp_we[g]),
        .fp_data(fp_wr.data),
        .value(regs[g])
      );
    end
  endgenerate

  assign ahb_go = hsel && htrans[1] && hready;

  // Fault events
  always_comb begin
    ev = 2'h0;
    case (act)
      pfa_pkg::ACT_BADOP: ev[`PFA_EV_BADOP] = 1'b1;
      pfa_pkg::ACT_UNAVAIL: ev[`PFA_EV_UNAVAIL] = 1'b1;
      pfa_pkg::ACT_EXEC: ev = 2'h0;
      pfa_pkg::ACT_NONE: ev = 2'h0;
      default: ev = 2'h0;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.done = exec;
    s_d.badop = ev[`PFA_EV_BADOP];
    s_d.unavail = ev[`PFA_EV_UNAVAIL];
    s_d.fp_rd = regs[fp_rd_idx];
    if (exec) begin
      s_d.pk_rd = regs[instr.src][63:0];
    end

    // Floating side writes of status and tags
    if (fpsw_we) begin
      s_d.fpsw = fpsw_wdata;
    end
    if (ftw_we) begin
      s_d.ftw = ftw_wdata;
    end

    // Packed instruction side effects override same-cycle floating writes
    if (exec) begin
      s_d.fpsw[`PFA_TOP_HI:`PFA_TOP_LO] = `PFA_TOP_ZERO;
      if (instr.clear) begin
        s_d.ftw = `PFA_TAGS_EMPTY;
      end else begin
        s_d.ftw = `PFA_TAGS_VALID;
      end
    end

    // Bus data phase write
    if (s_q.a_wr) begin
      case (s_q.a_off)
        `PFA_OFF_CTRL: s_d.ctrl = hwdata[2:0];
        `PFA_OFF_STS: s_d.sts = s_q.sts & ~hwdata[1:0];
        `PFA_OFF_MASK: s_d.mask = hwdata[1:0];
        default: s_d.ctrl = s_d.ctrl;
      endcase
    end
    // Event set wins over clear
    s_d.sts = s_d.sts | ev;
    s_d.irq = |(s_d.sts & s_d.mask);

    // Address phase capture
    s_d.a_wr = ahb_go && hwrite;
    s_d.a_rd = ahb_go && !hwrite;
    s_d.a_off = ahb_go ? haddr[7:0] : s_q.a_off;

    // Read mux from next state so a preceding write is seen
    case (haddr[7:0])
      `PFA_OFF_CTRL: rd_mux = {29'h0, s_d.ctrl};
      `PFA_OFF_STS: rd_mux = {30'h0, s_d.sts};
      `PFA_OFF_MASK: rd_mux = {30'h0, s_d.mask};
      `PFA_OFF_FPSW: rd_mux = {16'h0, s_d.fpsw};
      `PFA_OFF_FTW: rd_mux = {16'h0, s_d.ftw};
      default: rd_mux = 32'h0;
    endcase
    s_d.rdata = (ahb_go && !hwrite) ? rd_mux : 32'h0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '{
        ctrl: `PFA_CTRL_RST,
        sts: `PFA_EV_RST,
        mask: `PFA_EV_RST,
        fpsw: `PFA_FPSW_RST,
        ftw: `PFA_TAGS_EMPTY,
        a_wr: 1'b0,
        a_rd: 1'b0,
        a_off: 8'h00,
        rdata: 32'h0,
        done: 1'b0,
        badop: 1'b0,
        unavail: 1'b0,
        pk_rd: 64'h0,
        fp_rd: 80'h0,
        irq: 1'b0
      };
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_q.rdata;
  assign instr_done = s_q.done;
  assign invalid_opcode_fault = s_q.badop;
  assign device_unavailable_fault = s_q.unavail;
  assign pk_rd_data = s_q.pk_rd;
  assign fp_rd_data = s_q.fp_rd;
  assign fp_status_word = s_q.fpsw;
  assign fp_tag_word = s_q.ftw;
  assign irq = s_q.irq;

endmodule : pfa_regfile

// ### dv/pfa_pipe_model.sv
`timescale 1ns/1ps
module pfa_pipe_model (
  // Issue request
  input wire logic hclk,
  input wire logic go,
  input wire logic [71:0] req,
  output pfa_pkg::pk_instr_t instr
);
  // Idle cycles carry inverted data, never stale
  always_ff @(posedge hclk) begin
    instr <= go ? {1'h1, req} : {1'h0, ~req};
  end
endmodule : pfa_pipe_model

// ### dv/pfa_regfile_asserts.sv
`timescale 1ns/1ps
module pfa_regfile_asserts (
  // Watched ports
  input wire logic hclk,
  input wire logic hresetn,
  input wire pfa_pkg::pk_instr_t instr,
  input wire logic instr_done,
  input wire logic invalid_opcode_fault,
  input wire logic device_unavailable_fault,
  input wire logic [63:0] pk_rd_data,
  input wire logic fpsw_we,
  input wire logic ftw_we,
  input wire logic [15:0] fp_status_word,
  input wire logic [15:0] fp_tag_word
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [2:0] ans;
  logic flt;
  assign ans = {instr_done, invalid_opcode_fault, device_unavailable_fault};
  assign flt = invalid_opcode_fault || device_unavailable_fault;
  sequence s_pk; instr.valid && !instr.clear ##1 instr_done; endsequence
  sequence s_clr; instr.valid && instr.clear ##1 instr_done; endsequence
  one_answer_a: assert property (instr.valid |=> $onehot(ans))
    else $error("bad answer");
  no_answer_a: assert property (!instr.valid |=> ans == 3'h0)
    else $error("spurious answer");
  tags_valid_a: assert property (s_pk |-> fp_tag_word == 16'h0000)
    else $error("tags not valid");
  tags_empty_a: assert property (s_clr |-> fp_tag_word == 16'hFFFF)
    else $error("tags not empty");
  top_zero_a: assert property (instr_done |-> fp_status_word[13:11] == 3'h0)
    else $error("top not zero");
  sw_keep_a: assert property (instr_done && !$past(fpsw_we) |->
    {fp_status_word[15:14], fp_status_word[10:0]} ==
    {$past(fp_status_word[15:14]), $past(fp_status_word[10:0])}) else $error("status lost");
  fault_keep_a: assert property (flt && !$past(ftw_we) |-> $stable(fp_tag_word))
    else $error("fault changed tags");
  pk_hold_a: assert property (!instr_done |-> $stable(pk_rd_data))
    else $error("read data moved");
endmodule : pfa_regfile_asserts
bind pfa_regfile pfa_regfile_asserts u_chk (.hclk, .hresetn, .instr, .instr_done,
  .invalid_opcode_fault, .device_unavailable_fault, .pk_rd_data, .fpsw_we, .ftw_we,
  .fp_status_word, .fp_tag_word);

// ### dv/packed_simd_fp_alias_regfile_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; \
  $display("Error %0t got %0h exp %0h", $time, a, b); end end
module packed_simd_fp_alias_regfile_tb_top;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, go = 0, fpsw_we = 0, ftw_we = 0;
  logic hreadyout, hresp, instr_done, invalid_opcode_fault, device_unavailable_fault, irq;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd, s = 32'h54;
  logic [1:0] htrans = '0, m_sts, m_mask;
  logic [2:0] hsize = 3'h2, fp_rd_idx = '0, e;
  logic [15:0] fpsw_wdata = '0, ftw_wdata = '0, fp_status_word, fp_tag_word;
  logic [15:0] m_tags = 16'hFFFF, m_fpsw = '0;
  logic [63:0] pk_rd_data, m_pk = '0;
  logic [79:0] fp_rd_data, m_reg [8] = '{default: '0};
  logic [71:0] req = '0;
  logic emu_f = 0, tsk_f = 0;
  int error_cnt = 0, compares = 0;
  pfa_pkg::pk_instr_t instr;
  pfa_pkg::fp_wr_t fp_wr = '0;
  always #12.5 hclk = ~hclk;
  pfa_pipe_model u_pipe (.hclk, .go, .req, .instr);
  pfa_regfile u_dut (.*, .hready(hreadyout));
  function logic [31:0] rnd;
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : rnd
  task close_out;
    $display("compares=%0d errors=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task rdy;
    int k;
    k = 0;
    do begin @(posedge hclk); k++; end while (hreadyout !== 1'h1 && k < 50);
    if (hreadyout !== 1'h1) begin error_cnt++; close_out; end
    rd = hrdata;
    `CHK(hresp, 1'h0)
  endtask : rdy
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    rdy;
    htrans <= 2'h0; hwdata <= d;
    rdy;
  endtask : ahb
  task issue(input logic c, input logic w, input logic [2:0] d, sr, input logic [63:0] v);
    @(posedge hclk);
    go <= 1'h1; req <= {c, w, d, sr, v};
    @(posedge hclk);
    go <= 1'h0;
    e = emu_f ? 3'h2 : tsk_f ? 3'h1 : 3'h4;
    if (e[2]) begin
      m_pk = m_reg[sr][63:0];
      m_tags = c ? 16'hFFFF : 16'h0000;
      m_fpsw[13:11] = 3'h0;
      if (w && !c) m_reg[d] = {16'hFFFF, v};
    end
    @(posedge hclk); #1;
    `CHK({instr_done, invalid_opcode_fault, device_unavailable_fault}, e)
    `CHK(fp_tag_word, m_tags)
    `CHK(fp_status_word, m_fpsw)
    `CHK(pk_rd_data, m_pk)
  endtask : issue
  task fpchk(input int n);
    @(posedge hclk) fp_rd_idx <= n[2:0];
    repeat (2) @(posedge hclk);
    #1 `CHK(fp_rd_data, m_reg[n])
  endtask : fpchk
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    ahb(1'h0, 8'h00, '0);
    `CHK(rd, 32'h2)
    ahb(1'h0, 8'h14, '0);
    `CHK(rd, 32'h0)
    ahb(1'h1, 8'h08, 32'h1);
    for (int n = 0; n < 8; n++) begin
      m_reg[n] = {rnd(), rnd(), 16'hC0DE};
      @(posedge hclk) fp_wr <= {1'h1, n[2:0], m_reg[n]};
      @(posedge hclk) fp_wr.we <= 1'h0;
      issue(1'h0, 1'h0, 3'h0, n[2:0], 64'h0);
      issue(1'h0, 1'h1, n[2:0], 3'(7 - n), {rnd(), rnd()});
      fpchk(n);
    end
    $display("alias test done");
    rd = rnd();
    m_fpsw = rd[15:0];
    m_tags = rd[31:16];
    @(posedge hclk) begin
      fpsw_we <= 1'h1;
      fpsw_wdata <= rd[15:0];
      ftw_we <= 1'h1;
      ftw_wdata <= rd[31:16];
    end
    @(posedge hclk) begin
      fpsw_we <= 1'h0;
      ftw_we <= 1'h0;
    end
    #1 `CHK(fp_tag_word, m_tags)
    ahb(1'h0, 8'h0C, '0);
    `CHK(rd, {16'h0, m_fpsw})
    issue(1'h0, 1'h0, 3'h0, 3'h0, 64'h0);
    issue(1'h1, 1'h1, 3'h2, 3'h2, 64'h0);
    fpchk(2);
    $display("status and clear test done");
    for (int c = 0; c < 4; c++) begin
      {emu_f, tsk_f} = 2'(c);
      m_mask = 2'(c) ^ 2'h2;
      ahb(1'h1, 8'h08, {30'h0, m_mask});
      ahb(1'h0, 8'h08, '0);
      `CHK(rd, {30'h0, m_mask})
      ahb(1'h1, 8'h00, {29'h0, tsk_f, 1'h1, emu_f});
      issue(1'h0, 1'h1, 3'h5, 3'h5, {rnd(), rnd()});
      fpchk(5);
      m_sts = {!emu_f && tsk_f, emu_f};
      ahb(1'h0, 8'h04, '0);
      `CHK(rd, {30'h0, m_sts})
      `CHK(irq, |(m_sts & m_mask))
      ahb(1'h1, 8'h04, 32'h3);
      ahb(1'h0, 8'h10, '0);
      `CHK(rd, {16'h0, m_tags})
      `CHK(irq, 1'h0)
    end
    $display("gating test done");
    close_out;
  end
  initial begin
    #2000000;
    error_cnt++;
    close_out;
  end
endmodule : packed_simd_fp_alias_regfile_tb_top
